// *** rtl/timer_pwm_pkg.sv ***
// Package with register map, field layout, encodings and reset values of the timer unit.
// Behaviour
// RULE1: Up-counting sets overflow flag when counter rolls to 0x0000 after modulo value.
// RULE2: Center-aligned mode sets overflow flag stepping down after reaching modulo value.
// RULE3: Flag clears only by status read while set, then writing 0 to bit 7.
// RULE4: New overflow during clearing sequence restarts it, so the flag stays set.
// RULE5: Writing 1 to the flag does nothing; reset clears the flag.
// RULE6: Overflow interrupt enable, bit 6, read/write, reset clear, requests interrupt while flag set.
// RULE7: Center-align select, bit 5: clear counts up only, set counts up and down.
// RULE8: Clock source field at bits 4:3 disables timer or picks one of three sources.
// RULE9: External and fixed system clocks are synchronised to the bus clock first.
// RULE10: Prescale field at bits 2:0 selects one of eight divisors.
// RULE11: Prescaler follows synchronisation and source selection, dividing whichever source is chosen.
// RULE12: All status/control bits reset to zero.
// RULE13: In compare or PWM modes channel value byte writes go to a buffer.
// RULE14: Once both bytes are written they move together into the active 16-bit value.
// RULE15: Bytes may come in either order; channel status/control write resets pairing.
// RULE16: Clock source resets to 0:0, timer off; 0:1 selects the bus clock.
// RULE17: External clock must run at most one-fourth of the bus clock rate.
// RULE18: Counter pauses in background debug, stops with clocks, runs in wait.
// RULE19: Up-counter runs 0x0000 to terminal count, 0xFFFF unless modulo programmed.
// RULE20: Prescale settings divide by 1, 2, 4, 8, 16, 32, 64, 128 ascending.
package timer_pwm_pkg;

    localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_COUNTER_VALUE = 8'h04;
    localparam logic [7:0] OFS_MODULO_VALUE = 8'h08;
    localparam logic [7:0] OFS_CHANNEL_STATUS = 8'h0C;
    localparam logic [7:0] OFS_CHANNEL_HIGH = 8'h10;
    localparam logic [7:0] OFS_CHANNEL_LOW = 8'h14;
    localparam logic [7:0] OFS_CHANNEL_ACTIVE = 8'h18;

    localparam int FLAG_BIT = 7;
    localparam int CH_MODE_LSB = 2;

    localparam logic [7:0] SC_RESET = 8'h00;
    localparam logic [7:0] CH_SC_RESET = 8'h00;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_STEP = 16'h0001;
    localparam logic [1:0] CH_MODE_CAPTURE = 2'h0;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CLK_OFF = 2'h0,
        CLK_BUS = 2'h1,
        CLK_FIXED = 2'h2,
        CLK_EXT = 2'h3
    } clk_src_t;

    typedef enum logic [1:0] {
        DIR_UP = 2'b01,
        DIR_DOWN = 2'b10
    } dir_t;

    typedef struct packed {
        logic overflow_flag;
        logic overflow_irq_enable;
        logic center_align_select;
        clk_src_t clock_source_sel;
        logic [2:0] prescale_select;
    } status_control_t;

endpackage : timer_pwm_pkg

// *** rtl/timer_clock_prescaler.sv ***
// Clock source synchroniser, source selection and prescaler producing counter ticks.
`timescale 1ns/1ps
module timer_clock_prescaler (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control
    input timer_pwm_pkg::clk_src_t clk_sel,
    input wire logic [2:0] prescale,
    input wire logic pause,
    input wire logic restart,
    // Raw clock sources
    input wire logic ext_clock_in,
    input wire logic fixed_system_clock,
    // Counter tick
    output logic tick
);
    import timer_pwm_pkg::*;

    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] last;
    logic [6:0] pcount;
    logic [6:0] next_pcount;
    logic [6:0] mask;
    logic [1:0] rise;
    logic src_edge;
    logic advance;
    logic next_tick;

    always_comb begin
        rise = sync & ~last;
        case (clk_sel) // RULE8
            CLK_OFF: src_edge = 1'b0; // RULE16
            CLK_BUS: src_edge = 1'b1; // RULE16
            CLK_FIXED: src_edge = rise[0];
            CLK_EXT: src_edge = rise[1];
            default: src_edge = 1'b0;
        endcase
        advance = src_edge && !pause; // RULE18
        mask = 7'((8'h01 << prescale) - 8'h01); // RULE10 RULE20
        next_tick = advance && ((pcount & mask) == mask); // RULE11
        if (restart) begin
            next_pcount = '0;
        end else if (advance) begin
            next_pcount = pcount + 7'h01;
        end else begin
            next_pcount = pcount;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            meta <= 2'h0;
            sync <= 2'h0;
            last <= 2'h0;
            pcount <= 7'h00;
            tick <= 1'b0;
        end else begin
            meta <= {ext_clock_in, fixed_system_clock}; // RULE9
            sync <= meta; // RULE9
            last <= sync;
            pcount <= next_pcount;
            tick <= next_tick;
        end
    end

endmodule : timer_clock_prescaler

// *** rtl/timer_pwm_status_control.sv ***
// Timer status/control, counter, overflow flag, channel value pairing and AXI4-Lite slave.
//
// Design decisions made here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module timer_pwm_status_control (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // AXI4-Lite write address
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // AXI4-Lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read address
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // AXI4-Lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Clock sources and debug state
    input wire logic ext_clock_in,
    input wire logic fixed_system_clock,
    input wire logic background_active,
    // Timer outputs
    output logic overflow_irq,
    output logic center_aligned_pwm,
    output logic [15:0] counter_value,
    output logic [15:0] channel_value
);
    import timer_pwm_pkg::*;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == OFS_STATUS_CONTROL) || (a == OFS_COUNTER_VALUE) ||
            (a == OFS_MODULO_VALUE) || (a == OFS_CHANNEL_STATUS) ||
            (a == OFS_CHANNEL_HIGH) || (a == OFS_CHANNEL_LOW) ||
            (a == OFS_CHANNEL_ACTIVE);
    endfunction : is_mapped

    // Bus state.
    logic aw_full;
    logic w_full;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic next_aw_full;
    logic next_w_full;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic do_write;
    logic do_read;
    logic [7:0] rd_addr;

    // Timer state.
    status_control_t sc;
    status_control_t next_sc;
    logic [15:0] modulo_value;
    logic [15:0] next_modulo;
    logic [15:0] next_counter;
    dir_t dir;
    dir_t next_dir;
    logic clear_armed;
    logic next_clear_armed;
    logic [7:0] ch_sc;
    logic [7:0] next_ch_sc;
    logic [7:0] buf_high;
    logic [7:0] buf_low;
    logic [7:0] next_buf_high;
    logic [7:0] next_buf_low;
    logic high_written;
    logic low_written;
    logic next_high_written;
    logic next_low_written;
    logic [15:0] next_channel;
    logic next_irq;
    logic next_center_out;
    logic tick;
    logic overflow;
    logic buffered;
    logic [15:0] terminal;
    logic wr_sc;
    logic wr_counter;
    logic wr_ch_sc;
    logic wr_high;
    logic wr_low;

    timer_clock_prescaler prescaler (
        .mclk(mclk),
        .rst(rst),
        .clk_sel(sc.clock_source_sel),
        .prescale(sc.prescale_select),
        .pause(background_active),
        .restart(wr_counter),
        .ext_clock_in(ext_clock_in),
        .fixed_system_clock(fixed_system_clock),
        .tick(tick)
    );

    // Bus handshakes: address and data are taken in either order, one write and one read.
    always_comb begin
        next_aw_full = aw_full;
        next_w_full = w_full;
        next_aw_addr = aw_addr_q;
        next_w_data = w_data_q;
        next_w_strb = w_strb_q;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        rd_addr = araddr[7:0];
        if (awvalid && awready) begin
            next_aw_full = 1'b1;
            next_aw_addr = awaddr[7:0];
        end
        if (wvalid && wready) begin
            next_w_full = 1'b1;
            next_w_data = wdata;
            next_w_strb = wstrb;
        end
        do_write = aw_full && w_full && !bvalid;
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_full = 1'b0;
            next_w_full = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
        end
        next_awready = !next_aw_full && !next_bvalid;
        next_wready = !next_w_full && !next_bvalid;
        do_read = arvalid && arready;
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (do_read) begin
            next_rvalid = 1'b1;
            next_rresp = is_mapped(rd_addr) ? RESP_OKAY : RESP_SLVERR;
            case (rd_addr)
                OFS_STATUS_CONTROL: next_rdata = {24'h000000, sc};
                OFS_COUNTER_VALUE: next_rdata = {16'h0000, counter_value};
                OFS_MODULO_VALUE: next_rdata = {16'h0000, modulo_value};
                OFS_CHANNEL_STATUS: next_rdata = {24'h000000, ch_sc};
                OFS_CHANNEL_HIGH: next_rdata = {24'h000000, buf_high};
                OFS_CHANNEL_LOW: next_rdata = {24'h000000, buf_low};
                OFS_CHANNEL_ACTIVE: next_rdata = {16'h0000, channel_value};
                default: next_rdata = 32'h00000000;
            endcase
        end
        next_arready = !next_rvalid;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= RESP_OKAY;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            aw_addr_q <= next_aw_addr;
            w_data_q <= next_w_data;
            w_strb_q <= next_w_strb;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    // Counter, overflow flag and its clearing sequence.
    always_comb begin
        wr_sc = do_write && (aw_addr_q == OFS_STATUS_CONTROL) && w_strb_q[0];
        wr_counter = do_write && (aw_addr_q == OFS_COUNTER_VALUE);
        terminal = (modulo_value == COUNT_ZERO) ? COUNT_MAX : modulo_value; // RULE19
        next_counter = counter_value;
        next_dir = dir;
        overflow = 1'b0;
        if (tick) begin
            case (dir)
                DIR_UP: begin
                    if (sc.center_align_select) begin // RULE7
                        if (counter_value >= modulo_value && counter_value != COUNT_ZERO) begin
                            next_dir = DIR_DOWN;
                            next_counter = counter_value - COUNT_STEP;
                            overflow = 1'b1; // RULE2
                        end else begin
                            next_counter = counter_value + COUNT_STEP;
                        end
                    end else if (counter_value == terminal) begin
                        next_counter = COUNT_ZERO; // RULE19
                        overflow = 1'b1; // RULE1
                    end else begin
                        next_counter = counter_value + COUNT_STEP;
                    end
                end
                DIR_DOWN: begin
                    if (!sc.center_align_select || counter_value == COUNT_ZERO) begin
                        next_dir = DIR_UP;
                        next_counter = counter_value + COUNT_STEP;
                    end else begin
                        next_counter = counter_value - COUNT_STEP;
                    end
                end
                default: begin
                    next_dir = DIR_UP;
                    next_counter = COUNT_ZERO;
                end
            endcase
        end
        if (wr_counter) begin
            next_counter = COUNT_ZERO;
            next_dir = DIR_UP;
        end
        next_sc = sc;
        next_clear_armed = clear_armed;
        if (do_read && rd_addr == OFS_STATUS_CONTROL && sc.overflow_flag) begin
            next_clear_armed = 1'b1; // RULE3
        end
        if (wr_sc) begin
            next_sc = status_control_t'(w_data_q[7:0]); // RULE6 RULE7 RULE8 RULE10
            next_sc.overflow_flag = sc.overflow_flag; // RULE5
            if (clear_armed && !w_data_q[FLAG_BIT]) begin
                next_sc.overflow_flag = 1'b0; // RULE3
            end
            next_clear_armed = 1'b0;
        end
        if (overflow) begin
            next_sc.overflow_flag = 1'b1;
            next_clear_armed = 1'b0; // RULE4
        end
        next_modulo = modulo_value;
        if (do_write && aw_addr_q == OFS_MODULO_VALUE) begin
            if (w_strb_q[0]) begin
                next_modulo[7:0] = w_data_q[7:0];
            end
            if (w_strb_q[1]) begin
                next_modulo[15:8] = w_data_q[15:8];
            end
        end
        next_irq = next_sc.overflow_flag && next_sc.overflow_irq_enable; // RULE6
        next_center_out = next_sc.center_align_select;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            sc <= status_control_t'(SC_RESET); // RULE12 RULE5 RULE16
            modulo_value <= COUNT_ZERO;
            counter_value <= COUNT_ZERO;
            dir <= DIR_UP;
            clear_armed <= 1'b0;
            overflow_irq <= 1'b0;
            center_aligned_pwm <= 1'b0;
        end else begin
            sc <= next_sc;
            modulo_value <= next_modulo;
            counter_value <= next_counter;
            dir <= next_dir;
            clear_armed <= next_clear_armed;
            overflow_irq <= next_irq;
            center_aligned_pwm <= next_center_out;
        end
    end

    // Channel value byte pairing.
    always_comb begin
        wr_ch_sc = do_write && (aw_addr_q == OFS_CHANNEL_STATUS) && w_strb_q[0];
        wr_high = do_write && (aw_addr_q == OFS_CHANNEL_HIGH) && w_strb_q[0];
        wr_low = do_write && (aw_addr_q == OFS_CHANNEL_LOW) && w_strb_q[0];
        buffered = sc.center_align_select ||
            (ch_sc[CH_MODE_LSB +: 2] != CH_MODE_CAPTURE); // RULE13
        next_ch_sc = ch_sc;
        next_buf_high = buf_high;
        next_buf_low = buf_low;
        next_high_written = high_written;
        next_low_written = low_written;
        next_channel = channel_value;
        if (wr_high) begin
            next_buf_high = w_data_q[7:0];
            if (buffered) begin
                next_high_written = 1'b1; // RULE13
            end else begin
                next_channel[15:8] = w_data_q[7:0];
            end
        end
        if (wr_low) begin
            next_buf_low = w_data_q[7:0];
            if (buffered) begin
                next_low_written = 1'b1; // RULE13
            end else begin
                next_channel[7:0] = w_data_q[7:0];
            end
        end
        if (next_high_written && next_low_written) begin
            next_channel = {next_buf_high, next_buf_low}; // RULE14 RULE15
            next_high_written = 1'b0;
            next_low_written = 1'b0;
        end
        if (wr_ch_sc) begin
            next_ch_sc = w_data_q[7:0];
            next_high_written = 1'b0; // RULE15
            next_low_written = 1'b0; // RULE15
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ch_sc <= CH_SC_RESET;
            buf_high <= 8'h00;
            buf_low <= 8'h00;
            high_written <= 1'b0;
            low_written <= 1'b0;
            channel_value <= COUNT_ZERO;
        end else begin
            ch_sc <= next_ch_sc;
            buf_high <= next_buf_high;
            buf_low <= next_buf_low;
            high_written <= next_high_written;
            low_written <= next_low_written;
            channel_value <= next_channel;
        end
    end

endmodule : timer_pwm_status_control

// *** verification/timer_pwm_status_control_chk.sv ***
// Checker of bus handshakes and timer outputs of the timer status/control block.
`timescale 1ns/1ps
module timer_pwm_status_control_chk (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic rvalid,
    input wire logic rready,
    // Timer
    input wire logic background_active,
    input wire logic overflow_irq,
    input wire logic center_aligned_pwm,
    input wire logic [15:0] counter_value,
    input wire logic [15:0] channel_value
);
    import timer_pwm_pkg::*;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    write_answer_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write response not two cycles after the handshake");
    read_answer_a: assert property (arvalid && arready |=> rvalid)
        else $error("read data not one cycle after the address");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped before it was taken");
    rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped before it was taken");
    write_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("write accepted while a response is pending");
    read_block_a: assert property (rvalid |-> !arready)
        else $error("read accepted while read data is pending");
    center_write_a: assert property ($changed(center_aligned_pwm) |-> $rose(bvalid))
        else $error("center select changed without a write");
    channel_load_a: assert property ($changed(channel_value) |-> $rose(bvalid))
        else $error("channel value changed without a write");
    debug_pause_a: assert property (background_active && $past(background_active)
        && $past(background_active, 2) && !$rose(bvalid) |-> $stable(counter_value))
        else $error("counter moved while paused");
    reset_clear_a: assert property ($fell(rst) |->
        counter_value == 16'h0000 && !overflow_irq && !center_aligned_pwm)
        else $error("outputs not cleared by reset");
    cover property ($rose(overflow_irq));
    cover property ($changed(channel_value));
    cover property (bvalid && bresp == RESP_SLVERR);
endmodule : timer_pwm_status_control_chk

bind timer_pwm_status_control timer_pwm_status_control_chk u_chk (
    .mclk, .rst, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
    .arvalid, .arready, .rdata, .rvalid, .rready, .background_active, .overflow_irq,
    .center_aligned_pwm, .counter_value, .channel_value
);

// *** verification/timer_pwm_status_control_tb_top.sv ***
// Self-checking testbench for the timer status/control block.
`timescale 1ns/1ps
module timer_pwm_status_control_tb_top;
    import timer_pwm_pkg::*;
    logic mclk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] awaddr, wdata, araddr, rdata, rd_data;
    logic [3:0] wstrb, div;
    logic [1:0] bresp, rresp, last_resp;
    logic ext_clock_in, fixed_system_clock, background_active;
    logic overflow_irq, center_aligned_pwm;
    logic [15:0] counter_value, channel_value, chv, c1;
    logic [7:0] h, l;
    int failures, samples_checked, m;

    timer_pwm_status_control u_dut (
        .mclk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
        .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready, .ext_clock_in, .fixed_system_clock, .background_active, .overflow_irq,
        .center_aligned_pwm, .counter_value, .channel_value
    );

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end

    // External source runs at one eighth, fixed source at one sixteenth of the bus rate.
    always @(posedge mclk) begin
        div <= div + 4'h1;
        ext_clock_in <= div[2];
        fixed_system_clock <= div[3];
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        awaddr <= {24'h000000, a};
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        fork
            begin
                do @(posedge mclk); while (awready !== 1'b1);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge mclk); while (wready !== 1'b1);
                wvalid <= 1'b0;
            end
        join
        repeat ($urandom % 3) @(posedge mclk);
        bready <= 1'b1;
        do @(posedge mclk); while (bvalid !== 1'b1);
        last_resp = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        araddr <= {24'h000000, a};
        arvalid <= 1'b1;
        do @(posedge mclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        repeat ($urandom % 3) @(posedge mclk);
        rready <= 1'b1;
        do @(posedge mclk); while (rvalid !== 1'b1);
        rd_data = rdata;
        last_resp = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic wait_count(input logic [15:0] v);
        int n;
        n = 0;
        while (counter_value !== v && n < 300) begin
            @(posedge mclk);
            n++;
        end
        check("count reached", n < 300, 1);
    endtask : wait_count

    task automatic rate(input int src, input int ps);
        wr(OFS_STATUS_CONTROL, 32'h0);
        wr(OFS_COUNTER_VALUE, 32'h0);
        wr(OFS_STATUS_CONTROL, src * 8 + ps);
        repeat (64) @(posedge mclk);
        c1 = counter_value;
        repeat (16 * ((src == 2 ? 16 : src == 3 ? 8 : 1) << ps)) @(posedge mclk);
        check("tick rate", 16'(counter_value - c1), src ? 16 : 0);
    endtask : rate

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (40000) @(posedge mclk);
        failures++;
        stop_test();
    end

    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready, background_active} = 7'h40;
        {awaddr, wdata, araddr, div} = '0;
        wstrb = 4'hF;
        void'($urandom(52082));
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rd(OFS_STATUS_CONTROL);
        check("sc reset", rd_data, 32'h0);
        repeat (4) begin
            m = $urandom & 32'h7F;
            if (m[5]) m[4:3] = 2'h0;
            wr(OFS_STATUS_CONTROL, m | 32'h80);
            rd(OFS_STATUS_CONTROL);
            check("sc rw", rd_data, m);
            check("center out", center_aligned_pwm, m[5]);
        end
        wr(OFS_MODULO_VALUE, 32'h0);
        for (int ps = 0; ps < 8; ps++) rate(1, ps);
        rate(0, 3);
        rate(2, $urandom % 3);
        rate(3, $urandom % 3);
        background_active <= 1'b1;
        repeat (4) @(posedge mclk);
        c1 = counter_value;
        repeat (32) @(posedge mclk);
        check("paused", counter_value, c1);
        background_active <= 1'b0;
        repeat (40) @(posedge mclk);
        check("resumed", counter_value != c1, 1);
        m = 3 + $urandom % 8;
        wr(OFS_STATUS_CONTROL, 32'h0);
        wr(OFS_MODULO_VALUE, m);
        wr(OFS_COUNTER_VALUE, 32'h0);
        wr(OFS_STATUS_CONTROL, 32'h48);
        wait_count(m[15:0]);
        check("irq early", overflow_irq, 0);
        @(posedge mclk);
        check("wrap", counter_value, 32'h0);
        repeat (2) @(posedge mclk);
        check("irq set", overflow_irq, 1);
        wr(OFS_STATUS_CONTROL, 32'h40);
        wr(OFS_STATUS_CONTROL, 32'h00);
        repeat (2) @(posedge mclk);
        check("irq masked", overflow_irq, 0);
        wr(OFS_STATUS_CONTROL, 32'h40);
        rd(OFS_STATUS_CONTROL);
        check("no read first", rd_data, 32'hC0);
        wr(OFS_STATUS_CONTROL, 32'hC0);
        rd(OFS_STATUS_CONTROL);
        check("write one", rd_data, 32'hC0);
        wr(OFS_STATUS_CONTROL, 32'h40);
        rd(OFS_STATUS_CONTROL);
        check("cleared", rd_data, 32'h40);
        repeat (2) @(posedge mclk);
        check("irq off", overflow_irq, 0);
        wr(OFS_MODULO_VALUE, 32'h3);
        wr(OFS_COUNTER_VALUE, 32'h0);
        wr(OFS_STATUS_CONTROL, 32'h48);
        repeat (8) @(posedge mclk);
        rd(OFS_STATUS_CONTROL);
        check("flag run", rd_data, 32'hC8);
        wr(OFS_STATUS_CONTROL, 32'h40);
        rd(OFS_STATUS_CONTROL);
        check("flag restart", rd_data, 32'hC0);
        wr(OFS_STATUS_CONTROL, 32'h0);
        wr(OFS_COUNTER_VALUE, 32'h0);
        wr(OFS_MODULO_VALUE, 32'h5);
        rd(OFS_STATUS_CONTROL);
        wr(OFS_STATUS_CONTROL, 32'h28);
        wait_count(16'h0005);
        check("center on", center_aligned_pwm, 1);
        @(posedge mclk);
        check("step down", counter_value, 32'h4);
        wr(OFS_STATUS_CONTROL, 32'h20);
        rd(OFS_STATUS_CONTROL);
        check("center flag", rd_data, 32'hA0);
        wr(OFS_STATUS_CONTROL, 32'h0);
        wr(OFS_CHANNEL_STATUS, 32'h4);
        chv = 16'h0000;
        for (int i = 0; i < 4; i++) begin
            h = 8'($urandom);
            l = 8'($urandom);
            wr(i[0] ? OFS_CHANNEL_LOW : OFS_CHANNEL_HIGH, i[0] ? l : h);
            check("chan held", channel_value, chv);
            if (i == 3) wr(OFS_CHANNEL_STATUS, 32'h4);
            wr(i[0] ? OFS_CHANNEL_HIGH : OFS_CHANNEL_LOW, i[0] ? h : l);
            if (i < 3) chv = {h, l};
            check("chan pair", channel_value, chv);
        end
        wr(OFS_CHANNEL_LOW, l);
        check("chan rearmed", channel_value, {h, l});
        wr(8'h40, 32'hFF);
        check("wr unmapped", last_resp, RESP_SLVERR);
        rd(8'h40);
        check("rd unmapped", {last_resp, rd_data[29:0]}, {RESP_SLVERR, 30'h0});
        stop_test();
    end
endmodule : timer_pwm_status_control_tb_top
